// file: rtl/mcad_core.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (RL1) add-with-carry into work register, four flags
// (RL2) add-with-carry into memory byte, four flags
// (RL3) add memory to work register, four flags
// (RL4) add immediate to work register, four flags
// (RL5) add work register into memory, four flags
// (RL6) and memory into work register, zero only
// (RL7) and immediate into work register, zero only
// (RL8) and work register into memory, zero only
// (RL9) call pushes pc plus one, loads target
// (RL10) call takes two cycles, flags untouched
// (RL11) clear memory byte to zero, flags untouched
// (RL12) 8-bit sum, carry bit7, half-carry bit3
// (RL13) memory read-modify-write inside one slot
module mcad_core
   import mcad_pkg::*;
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      nrst,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [mcad_pkg::APB_AW-1:0]  paddr,
   input  wire logic [mcad_pkg::APB_DW-1:0]  pwdata,
   output logic      [mcad_pkg::APB_DW-1:0]  prdata,
   output logic                           pready,
   output logic                           pslverr,
   // operations from the sequencer
   input  wire logic                      op_valid,
   input  wire logic [3:0]                op_code,
   input  wire logic [mcad_pkg::MADDR_W-1:0] op_addr,
   input  wire logic [mcad_pkg::DATA_W-1:0]  op_imm,
   input  wire logic [mcad_pkg::PC_W-1:0]    op_target,
   output logic                           op_ready,
   // return stack
   output logic                           stack_push,
   output logic      [mcad_pkg::PC_W-1:0]    stack_data,
   // program counter and state
   output logic      [mcad_pkg::PC_W-1:0]    pc,
   output logic      [mcad_pkg::DATA_W-1:0]  work_register,
   output logic                           carry_flag,
   output logic                           half_carry_flag,
   output logic                           zero_flag,
   output logic                           signed_range_flag
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      mcad_st_e            st;
      logic                ready;
      mcad_op_e            op;
      logic [MADDR_W-1:0]  addr;
      logic [PC_W-1:0]     tgt;
      logic [DATA_W-1:0]   wreg;
      logic                c;
      logic                hc;
      logic                z;
      logic                sr;
      logic [PC_W-1:0]     pc;
      logic                push;
      logic [PC_W-1:0]     push_data;
      logic [MADDR_W-1:0]  madr;
      logic                pready;
      logic                pslverr;
      logic [APB_DW-1:0]   prdata;
   } mcad_state_s;

   localparam mcad_state_s STATE_RST = '{
      st:        ST_IDLE,
      ready:     1'b1,
      op:        OP_NOP,
      addr:      MADR_RST,
      tgt:       PC_RST,
      wreg:      WREG_RST,
      c:         1'b0,
      hc:        1'b0,
      z:         1'b0,
      sr:        1'b0,
      pc:        PC_RST,
      push:      1'b0,
      push_data: PC_RST,
      madr:      MADR_RST,
      pready:    1'b0,
      pslverr:   1'b0,
      prdata:    WORD_0
   };

   mcad_state_s q;
   mcad_state_s next_q;

   // ---------------------------------------------------------------
   // memory port
   // ---------------------------------------------------------------
   logic                ram_we;
   logic [MADDR_W-1:0]  ram_waddr;
   logic [DATA_W-1:0]   ram_wdata;
   logic [MADDR_W-1:0]  ram_raddr;
   logic [DATA_W-1:0]   ram_rdata;

   mcad_ram u_ram (
      .clk   (clk),
      .we    (ram_we),
      .waddr (ram_waddr),
      .wdata (ram_wdata),
      .raddr (ram_raddr),
      .rdata (ram_rdata)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // 8-bit sum with carry out of bit 7, half-carry out of bit 3
   function automatic mcad_sum_s add8(
      input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b,
      input logic              cin
   );
      logic [NIB_W:0]  lo;
      logic [DATA_W:0] full;
      mcad_sum_s       r;
      lo     = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]}
               + {{NIB_W{1'b0}}, cin};
      full   = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
      r.sum  = full[DATA_W-1:0];
      r.c    = full[DATA_W];                                  // RL12
      r.hc   = lo[NIB_W];                                     // RL12
      r.sr   = (a[DATA_W-1] == b[DATA_W-1])
               && (r.sum[DATA_W-1] != a[DATA_W-1]);           // RL12
      return r;
   endfunction

   // operations that fetch an operand from data memory
   function automatic logic needs_mem(input mcad_op_e op);
      return (op == OP_SUM_ROLLOVER_TO_WREG)
          || (op == OP_SUM_WITH_ROLLOVER_TO_MEMORY)
          || (op == OP_SUM_FROM_MEMORY)
          || (op == OP_SUM_INTO_MEMORY)
          || (op == OP_MASK_FROM_MEMORY)
          || (op == OP_MASK_INTO_MEMORY);
   endfunction

   // operations whose result goes back to the memory byte
   function automatic logic to_mem(input mcad_op_e op);
      return (op == OP_SUM_WITH_ROLLOVER_TO_MEMORY)
          || (op == OP_SUM_INTO_MEMORY)
          || (op == OP_MASK_INTO_MEMORY);
   endfunction

   function automatic logic is_mask(input mcad_op_e op);
      return (op == OP_MASK_FROM_MEMORY)
          || (op == OP_MASK_INTO_MEMORY);
   endfunction

   // register decode, shared by reads and writes
   function automatic logic reg_known(input logic [APB_AW-1:0] a);
      return (a == REG_WREG) || (a == REG_FLAGS) || (a == REG_PC)
          || (a == REG_MADR) || (a == REG_MDATA);
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic        op_take;
   logic        apb_hit;
   mcad_op_e    op_in;
   mcad_sum_s   sum;
   logic [DATA_W-1:0] mask;
   logic [DATA_W-1:0] res;

   assign op_in = mcad_op_e'(op_code);

   always_comb begin
      next_q    = q;
      next_q.push    = 1'b0;
      next_q.pready  = 1'b0;
      next_q.pslverr = 1'b0;
      ram_we    = 1'b0;
      ram_waddr = q.addr;
      ram_wdata = ZERO_BYTE;
      ram_raddr = op_addr;
      sum       = add8(q.wreg, ram_rdata, 1'b0);
      mask      = q.wreg & ram_rdata;
      res       = ZERO_BYTE;
      // an operation always beats a bus access, so a busy
      // sequencer can hold the bus off indefinitely
      op_take   = q.ready && op_valid;
      apb_hit   = psel && penable && !q.pready;

      case (q.st)
         ST_IDLE: begin
            if (op_take) begin
               next_q.op   = op_in;
               next_q.addr = op_addr;
               next_q.tgt  = op_target;
               if (needs_mem(op_in)) begin
                  // operand read issued now, used next cycle
                  ram_raddr    = op_addr;                     // RL13
                  next_q.st    = ST_EXEC;
                  next_q.ready = 1'b0;
               end else begin
                  case (op_in)
                     OP_SUM_IMMEDIATE: begin
                        sum         = add8(q.wreg, op_imm, 1'b0);
                        next_q.wreg = sum.sum;                // RL4
                        next_q.c    = sum.c;                  // RL4
                        next_q.hc   = sum.hc;                 // RL4
                        next_q.sr   = sum.sr;                 // RL4
                        next_q.z    = (sum.sum == ZERO_BYTE); // RL4
                        next_q.pc   = q.pc + PC_STEP;
                     end
                     OP_MASK_IMMEDIATE: begin
                        mask        = q.wreg & op_imm;
                        next_q.wreg = mask;                   // RL7
                        next_q.z    = (mask == ZERO_BYTE);    // RL7
                        next_q.pc   = q.pc + PC_STEP;
                     end
                     OP_ZERO_MEMORY_BYTE: begin
                        ram_we      = 1'b1;                   // RL11
                        ram_waddr   = op_addr;                // RL11
                        ram_wdata   = ZERO_BYTE;              // RL11
                        next_q.pc   = q.pc + PC_STEP;
                     end
                     OP_CALL: begin
                        // first cycle: push the return address
                        next_q.push      = 1'b1;              // RL9
                        next_q.push_data = q.pc + PC_STEP;    // RL9
                        next_q.st        = ST_CALL2;          // RL10
                        next_q.ready     = 1'b0;              // RL10
                     end
                     default: begin
                        next_q.pc = q.pc + PC_STEP;
                     end
                  endcase
               end
            end else if (apb_hit) begin
               if (pwrite) begin
                  next_q.pready = 1'b1;
                  case (paddr)
                     REG_WREG: begin
                        next_q.wreg = pwdata[DATA_W-1:0];
                     end
                     REG_FLAGS: begin
                        next_q.c  = pwdata[FLG_C];
                        next_q.hc = pwdata[FLG_HC];
                        next_q.z  = pwdata[FLG_Z];
                        next_q.sr = pwdata[FLG_SR];
                     end
                     REG_MADR: begin
                        next_q.madr = pwdata[MADDR_W-1:0];
                     end
                     REG_MDATA: begin
                        ram_we    = 1'b1;
                        ram_waddr = q.madr;
                        ram_wdata = pwdata[DATA_W-1:0];
                     end
                     default: begin
                        // pc is read-only; writes are dropped
                        next_q.pslverr = !reg_known(paddr);
                     end
                  endcase
               end else if (paddr == REG_MDATA) begin
                  // memory read needs the extra ram cycle
                  ram_raddr    = q.madr;
                  next_q.st    = ST_APB_RD;
                  next_q.ready = 1'b0;
               end else begin
                  next_q.pready  = 1'b1;
                  next_q.pslverr = !reg_known(paddr);
                  case (paddr)
                     REG_WREG: begin
                        next_q.prdata = {{(APB_DW-DATA_W){1'b0}}, q.wreg};
                     end
                     REG_FLAGS: begin
                        next_q.prdata = WORD_0;
                        next_q.prdata[FLG_C]  = q.c;
                        next_q.prdata[FLG_HC] = q.hc;
                        next_q.prdata[FLG_Z]  = q.z;
                        next_q.prdata[FLG_SR] = q.sr;
                     end
                     REG_PC: begin
                        next_q.prdata = {{(APB_DW-PC_W){1'b0}}, q.pc};
                     end
                     REG_MADR: begin
                        next_q.prdata = {{(APB_DW-MADDR_W){1'b0}}, q.madr};
                     end
                     default: begin
                        next_q.prdata = WORD_0;
                     end
                  endcase
               end
            end
         end

         ST_EXEC: begin
            // operand from memory is valid this cycle
            next_q.st    = ST_IDLE;
            next_q.ready = 1'b1;
            next_q.pc    = q.pc + PC_STEP;
            if (is_mask(q.op)) begin
               res      = mask;
               next_q.z = (mask == ZERO_BYTE);                // RL6 RL8
            end else begin
               sum = add8(q.wreg, ram_rdata,
                          (q.op == OP_SUM_ROLLOVER_TO_WREG)
                          || (q.op == OP_SUM_WITH_ROLLOVER_TO_MEMORY)
                          ? q.c : 1'b0);                      // RL1 RL2 RL3 RL5
               res       = sum.sum;
               next_q.c  = sum.c;                             // RL1 RL2 RL3 RL5
               next_q.hc = sum.hc;                            // RL1 RL2 RL3 RL5
               next_q.sr = sum.sr;                            // RL1 RL2 RL3 RL5
               next_q.z  = (sum.sum == ZERO_BYTE);            // RL1 RL2 RL3 RL5
            end
            if (to_mem(q.op)) begin
               // written back before the next slot may read it
               ram_we    = 1'b1;                              // RL2 RL5 RL8 RL13
               ram_waddr = q.addr;                            // RL13
               ram_wdata = res;                               // RL2 RL5 RL8
            end else begin
               next_q.wreg = res;                             // RL1 RL3 RL6
            end
         end

         ST_CALL2: begin
            // second cycle: jump, flags left alone
            next_q.pc    = q.tgt;                             // RL9 RL10
            next_q.st    = ST_IDLE;
            next_q.ready = 1'b1;
         end

         ST_APB_RD: begin
            next_q.prdata = {{(APB_DW-DATA_W){1'b0}}, ram_rdata};
            next_q.pready = 1'b1;
            next_q.st     = ST_IDLE;
            next_q.ready  = 1'b1;
         end

         default: begin
            next_q = STATE_RST;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= STATE_RST;
      end else begin
         q <= next_q;
      end
   end

   // ---------------------------------------------------------------
   // outputs, all straight from q
   // ---------------------------------------------------------------
   assign prdata            = q.prdata;
   assign pready            = q.pready;
   assign pslverr           = q.pslverr;
   assign op_ready          = q.ready;
   assign stack_push        = q.push;
   assign stack_data        = q.push_data;
   assign pc                = q.pc;
   assign work_register     = q.wreg;
   assign carry_flag        = q.c;
   assign half_carry_flag   = q.hc;
   assign zero_flag         = q.z;
   assign signed_range_flag = q.sr;

endmodule
`default_nettype wire

// file: rtl/mcad_ram.sv
`timescale 1ns/100ps
`default_nettype none
module mcad_ram
   import mcad_pkg::*;
(
   // clock
   input  wire logic                      clk,
   // write port
   input  wire logic                      we,
   input  wire logic [mcad_pkg::MADDR_W-1:0] waddr,
   input  wire logic [mcad_pkg::DATA_W-1:0]  wdata,
   // read port, data one cycle later
   input  wire logic [mcad_pkg::MADDR_W-1:0] raddr,
   output logic      [mcad_pkg::DATA_W-1:0]  rdata
);

   logic [DATA_W-1:0] mem [MEM_DEPTH];

   // addresses past the top read zero and drop writes
   always_ff @(posedge clk) begin
      if (we && (waddr < MEM_DEPTH)) begin
         mem[waddr] <= wdata;
      end
      if (raddr < MEM_DEPTH) begin
         rdata <= mem[raddr];
      end else begin
         rdata <= ZERO_BYTE;
      end
   end

endmodule
`default_nettype wire

// file: shared/mcad_pkg.sv
`default_nettype none
package mcad_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int DATA_W  = 8;
   localparam int NIB_W   = 4;
   localparam int PC_W    = 11;
   localparam int MADDR_W = 7;
   localparam int APB_AW  = 12;
   localparam int APB_DW  = 32;

   // ---------------------------------------------------------------
   // data memory
   // ---------------------------------------------------------------
   localparam logic [MADDR_W-1:0] MEM_DEPTH = 7'h60;
   localparam logic [DATA_W-1:0]  ZERO_BYTE = 8'h00;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [APB_AW-1:0] REG_WREG  = 12'h000;
   localparam logic [APB_AW-1:0] REG_FLAGS = 12'h004;
   localparam logic [APB_AW-1:0] REG_PC    = 12'h008;
   localparam logic [APB_AW-1:0] REG_MADR  = 12'h00c;
   localparam logic [APB_AW-1:0] REG_MDATA = 12'h010;

   // ---------------------------------------------------------------
   // flag register fields
   // ---------------------------------------------------------------
   localparam int FLG_C  = 0;
   localparam int FLG_HC = 1;
   localparam int FLG_Z  = 2;
   localparam int FLG_SR = 3;

   // ---------------------------------------------------------------
   // reset values and steps
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0]  WREG_RST = 8'h00;
   localparam logic [PC_W-1:0]    PC_RST   = 11'h000;
   localparam logic [PC_W-1:0]    PC_STEP  = 11'h001;
   localparam logic [MADDR_W-1:0] MADR_RST = 7'h00;
   localparam logic [APB_DW-1:0]  WORD_0   = 32'h0000_0000;

   // ---------------------------------------------------------------
   // operations from the sequencer
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NOP                        = 4'h0,
      OP_SUM_ROLLOVER_TO_WREG       = 4'h1,
      OP_SUM_WITH_ROLLOVER_TO_MEMORY = 4'h2,
      OP_SUM_FROM_MEMORY            = 4'h3,
      OP_SUM_IMMEDIATE              = 4'h4,
      OP_SUM_INTO_MEMORY            = 4'h5,
      OP_MASK_FROM_MEMORY           = 4'h6,
      OP_MASK_IMMEDIATE             = 4'h7,
      OP_MASK_INTO_MEMORY           = 4'h8,
      OP_CALL                       = 4'h9,
      OP_ZERO_MEMORY_BYTE           = 4'ha
   } mcad_op_e;

   // ---------------------------------------------------------------
   // sequencer states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_EXEC   = 4'b0010,
      ST_CALL2  = 4'b0100,
      ST_APB_RD = 4'b1000
   } mcad_st_e;

   // ---------------------------------------------------------------
   // adder result
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              sr;
      logic              hc;
      logic              c;
      logic [DATA_W-1:0] sum;
   } mcad_sum_s;

endpackage
`default_nettype wire

// file: test/mcad_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mcad_core_monitor
   import mcad_pkg::*;
(
   // clock and reset
   input wire logic                        clk,
   input wire logic                        nrst,
   // operation port
   input wire logic                        op_valid,
   input wire logic [3:0]                  op_code,
   input wire logic [mcad_pkg::DATA_W-1:0] op_imm,
   input wire logic [mcad_pkg::PC_W-1:0]   op_target,
   input wire logic                        op_ready,
   // stack and state
   input wire logic                        stack_push,
   input wire logic [mcad_pkg::PC_W-1:0]   stack_data,
   input wire logic [mcad_pkg::PC_W-1:0]   pc,
   input wire logic [mcad_pkg::DATA_W-1:0] work_register,
   input wire logic                        carry_flag,
   input wire logic                        half_carry_flag,
   input wire logic                        zero_flag,
   input wire logic                        signed_range_flag
);
   // ------
   // helpers
   // ------
   wire logic       tk  = op_valid && op_ready;
   wire logic [3:0] flg = {signed_range_flag, zero_flag, half_carry_flag, carry_flag};
   wire logic [2:0] nz  = {signed_range_flag, half_carry_flag, carry_flag};
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ------
   // properties
   // ------
   call_push_a: assert property (tk && op_code == OP_CALL |=> stack_push && stack_data == $past(pc) + PC_STEP)
      else $error("call push wrong");
   call_target_a: assert property (tk && op_code == OP_CALL |=> ##1 pc == $past(op_target, 2))
      else $error("call target wrong");
   call_two_a: assert property (tk && op_code == OP_CALL |=> !op_ready ##1 op_ready)
      else $error("call length wrong");
   call_flags_a: assert property (tk && op_code == OP_CALL |=> $stable(flg) [*2])
      else $error("call flags");
   imm_add_a: assert property (tk && op_code == OP_SUM_IMMEDIATE |=>
      {carry_flag, work_register} == {1'b0, $past(work_register)} + {1'b0, $past(op_imm)}
      && zero_flag == (work_register == ZERO_BYTE)) else $error("imm add wrong");
   and_imm_a: assert property (tk && op_code == OP_MASK_IMMEDIATE |=> $stable(nz)
      && work_register == ($past(work_register) & $past(op_imm))) else $error("imm and wrong");
   clear_flags_a: assert property (tk && op_code == OP_ZERO_MEMORY_BYTE |=> $stable(flg))
      else $error("clear flags");
   mem_slot_a: assert property (tk && op_code inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8} |=> !op_ready ##1 op_ready)
      else $error("mem slot wrong");
   and_mem_a: assert property (tk && op_code inside {4'h6, 4'h8} |=> $stable(nz) [*2])
      else $error("mem and flags");
   mem_dest_a: assert property (tk && op_code inside {4'h2, 4'h5, 4'h8} |=> $stable(work_register) [*2])
      else $error("wreg changed");
endmodule
bind mcad_core mcad_core_monitor u_mon (.clk, .nrst, .op_valid, .op_code, .op_imm, .op_target, .op_ready,
   .stack_push, .stack_data, .pc, .work_register, .carry_flag, .half_carry_flag, .zero_flag, .signed_range_flag);
`default_nettype wire

// file: test/mcad_stack_model.sv
`timescale 1ns/100ps
`default_nettype none
module mcad_stack_model
   import mcad_pkg::*;
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      nrst,
   // push side of the core
   input  wire logic                      stack_push,
   input  wire logic [mcad_pkg::PC_W-1:0] stack_data,
   // to the bench
   output logic      [mcad_pkg::PC_W-1:0] top,
   output logic      [7:0]                depth
);
   // pushes only; returns live elsewhere
   always_ff @(posedge clk) begin
      if (!nrst) begin
         top   <= '0;
         depth <= '0;
      end else if (stack_push) begin
         top   <= stack_data;
         depth <= depth + 8'h01;
      end
   end
endmodule
`default_nettype wire

// file: test/tb_mcad_core.sv
`timescale 1ns/100ps
`default_nettype none
module tb_mcad_core;
   import mcad_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic        pready, pslverr, op_valid = 1'b0, op_ready, stack_push, c, hc, z, sr, er;
   logic [3:0]  op_code = '0, e_f;
   logic [6:0]  op_addr = '0;
   logic [7:0]  op_imm = '0, work_register, stk_depth, e_w, em [96];
   logic [10:0] op_target = '0, stack_data, pc, stk_top, e_pc, e_top;
   int          error_cnt = 0, samples_checked = 0;
   always #5 clk = ~clk;
   mcad_core dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .op_valid, .op_code, .op_addr, .op_imm, .op_target, .op_ready, .stack_push, .stack_data, .pc,
      .work_register, .carry_flag(c), .half_carry_flag(hc), .zero_flag(z), .signed_range_flag(sr));
   mcad_stack_model stk (.clk, .nrst, .stack_push, .stack_data, .top(stk_top), .depth(stk_depth));
   // ------
   // shared tasks
   // ------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk) n++; while (pready !== 1'b1 && n < 50);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("apb wait", n < 50, 1'b1);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      chk("read data", q, exp);
   endtask
   task automatic mset(input logic [6:0] a, input logic [7:0] d);
      apb(1'b1, REG_MADR, {25'h0, a});
      apb(1'b1, REG_MDATA, {24'h0, d});
      em[a] = d;
   endtask
   function automatic logic [10:0] add3(input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      return {a[7] == b[7] && s[7] != a[7], h[4], s};
   endfunction
   // one op, expected state, compare
   task automatic op(input logic [3:0] cd, input logic [6:0] a, input logic [7:0] im, input logic [10:0] tg);
      int n = 0;
      logic [7:0] b, m;
      logic [10:0] r;
      b = (cd inside {4'h4, 4'h7}) ? im : em[a];
      m = e_w & b;
      r = add3(e_w, b, (cd inside {4'h1, 4'h2}) && e_f[FLG_C]);
      e_pc = e_pc + PC_STEP;
      case (cd)
         4'h1, 4'h3, 4'h4: e_w = r[7:0];
         4'h2, 4'h5: em[a] = r[7:0];
         4'h6, 4'h7: e_w = m;
         4'h8: em[a] = m;
         4'h9: begin
            e_top = e_pc;
            e_pc  = tg;
         end
         4'ha: em[a] = ZERO_BYTE;
         default: ;
      endcase
      if (cd inside {[4'h1:4'h5]}) e_f = {r[10], r[7:0] == ZERO_BYTE, r[9], r[8]};
      if (cd inside {[4'h6:4'h8]}) e_f[FLG_Z] = (m == ZERO_BYTE);
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= cd;
      op_addr <= a;
      op_imm <= im;
      op_target <= tg;
      do @(posedge clk) n++; while (op_ready !== 1'b1 && n < 20);
      op_valid <= 1'b0;
      do @(posedge clk) n++; while (op_ready !== 1'b1 && n < 20);
      #1;
      chk("op wait", n < 20, 1'b1);
      chk("work register", work_register, e_w);
      chk("flags", {sr, z, hc, c}, e_f);
      chk("pc", pc, e_pc);
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_reset;
      rd(REG_WREG, WORD_0);
      rd(REG_FLAGS, WORD_0);
      apb(1'b1, REG_PC, 32'h0000_0005);
      rd(REG_PC, WORD_0);
      apb(1'b0, 12'h020, '0);
      chk("unmapped error", er, 1'b1);
      chk("unmapped data", q, WORD_0);
      $display("reset done");
   endtask
   task automatic t_imm;
      apb(1'b1, REG_WREG, 32'h7f);
      e_w = 8'h7f;
      op(4'h4, '0, 8'h01, '0);
      op(4'h4, '0, 8'h80, '0);
      apb(1'b1, REG_WREG, 32'hff);
      e_w = 8'hff;
      op(4'h7, '0, 8'h0f, '0);
      op(4'h7, '0, 8'hf0, '0);
      $display("immediate done");
   endtask
   task automatic t_mem;
      mset(7'h10, 8'h0f);
      mset(7'h5f, 8'h88);
      apb(1'b1, REG_WREG, 32'h01);
      apb(1'b1, REG_FLAGS, 32'h1);
      e_w = 8'h01;
      e_f = 4'h1;
      op(4'h1, 7'h10, '0, '0);
      op(4'h2, 7'h10, '0, '0);
      op(4'h1, 7'h10, '0, '0);
      op(4'h3, 7'h5f, '0, '0);
      op(4'h5, 7'h5f, '0, '0);
      op(4'h6, 7'h10, '0, '0);
      op(4'h8, 7'h5f, '0, '0);
      apb(1'b1, REG_MADR, 32'h10);
      rd(REG_MDATA, em[7'h10]);
      apb(1'b1, REG_MADR, 32'h5f);
      rd(REG_MDATA, em[7'h5f]);
      $display("memory done");
   endtask
   task automatic t_call;
      apb(1'b1, REG_FLAGS, 32'hf);
      e_f = 4'hf;
      op(4'h9, '0, '0, 11'h7ff);
      chk("stack top", stk_top, e_top);
      op(4'h9, '0, '0, 11'h123);
      op(4'h4, '0, 8'h00, '0);
      chk("stack top", stk_top, e_top);
      chk("stack depth", stk_depth, 8'h02);
      $display("call done");
   endtask
   task automatic t_clear;
      mset(7'h5f, 8'hff);
      apb(1'b1, REG_FLAGS, 32'h5);
      e_f = 4'h5;
      op(4'ha, 7'h5f, '0, '0);
      op(4'hf, 7'h5f, '0, '0);
      apb(1'b1, REG_MADR, 32'h5f);
      rd(REG_MDATA, 32'h0);
      $display("clear done");
   endtask
   // ------
   // main sequence and watchdog
   // ------
   initial begin
      e_w = '0;
      e_f = '0;
      e_pc = PC_RST;
      e_top = '0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_imm;
      t_mem;
      t_call;
      t_clear;
      close_out;
   end
   // far past any real run
   initial begin
      #200000;
      error_cnt++;
      $display("timeout");
      close_out;
   end
endmodule
`default_nettype wire
